/* adc_trig_pkg.sv */
// Package: register map, field positions and timing for converter control
// Function
// [R1] Special event trigger acts only with compare mode 1011 and converter powered.
// [R2] Accepted trigger sets go flag, starting conversion like a software write.
// [R3] Every special event trigger clears the timer one counter to zero.
// [R4] Converter off: trigger ignored, go flag unchanged, timer one still cleared.
// [R5] Software waits the acquisition interval after channel change before starting.
// [R6] Software powers converter first, sets go flag in a later write.
// [R7] Conversion start opens sampling switch, isolating hold capacitor throughout.
// [R8] Completion writes result, clears go flag in hardware, sets done flag.
package adc_trig_pkg;
    // ********************
    // Register offsets
    // ********************
    localparam logic [7:0] PORT_A_PINS_OFS      = 8'h05;
    localparam logic [7:0] CORE_INT_CTRL_OFS    = 8'h0B;
    localparam logic [7:0] PERIPH_FLAGS_OFS     = 8'h0C;
    localparam logic [7:0] CONV_RESULT_OFS      = 8'h1E;
    localparam logic [7:0] CONV_CTRL_MAIN_OFS   = 8'h1F;
    localparam logic [7:0] PORT_A_DIR_OFS       = 8'h85;
    localparam logic [7:0] PERIPH_ENABLES_OFS   = 8'h8C;
    localparam logic [7:0] CONV_PIN_CFG_OFS     = 8'h9F;
    localparam logic [7:0] COMPARE_CTRL_OFS     = 8'h17;
    localparam logic [7:0] TIMER_ONE_LO_OFS     = 8'h0E;
    localparam logic [7:0] TIMER_ONE_HI_OFS     = 8'h0F;
    // ********************
    // Reset values and masks
    // ********************
    localparam logic [7:0] CTRL_MAIN_RST        = 8'h00;
    localparam logic [7:0] CTRL_MAIN_MASK       = 8'hFD;
    localparam logic [7:0] PORT_A_DIR_RST       = 8'h3F;
    localparam logic [7:0] PORT_A_MASK          = 8'h3F;
    localparam logic [7:0] PIN_CFG_MASK         = 8'h07;
    localparam logic [7:0] FLAGS_MASK           = 8'h4F;
    localparam logic [7:0] COMPARE_MASK         = 8'h0F;
    // ********************
    // Field positions
    // ********************
    localparam int POWER_ON_BIT    = 0;
    localparam int GO_BIT          = 2;
    localparam int CHAN_LSB        = 3;
    localparam int CLKSEL_LSB      = 6;
    localparam int DONE_FLAG_BIT   = 6;
    localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB;
    // ********************
    // Timing
    // ********************
    localparam int CLK_MHZ          = 200;
    localparam int CONV_BITS        = 8;
    localparam int TAD_BASE_CYCLES  = 2;
endpackage : adc_trig_pkg

/* sar_engine.sv */
// Successive approximation sequencer with sampling switch control
`timescale 1ns/100ps
module sar_engine #(
    parameter int WIDTH = adc_trig_pkg::CONV_BITS
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             start,
    input  wire logic [1:0]       clk_sel,
    input  wire logic             comp_in,
    output logic                  sample_open,
    output logic [WIDTH-1:0]      dac_code,
    output logic                  done,
    output logic [WIDTH-1:0]      result
);
    typedef enum logic [1:0] {
        IDLE = 2'b01,
        CONV = 2'b10
    } sar_state_e;

    sar_state_e          state_r, state_nxt;
    logic [WIDTH-1:0]    code_r, code_nxt;
    logic [WIDTH-1:0]    bit_r, bit_nxt;
    logic [WIDTH-1:0]    res_r, res_nxt;
    logic [7:0]          tad_r, tad_nxt;
    logic                done_r, done_nxt;
    logic [7:0]          tad_len;

    // Bit period grows with clock select, 2,4,8,16 cycles
    assign tad_len = 8'(adc_trig_pkg::TAD_BASE_CYCLES << clk_sel);

    always_comb begin
        state_nxt = state_r;
        code_nxt  = code_r;
        bit_nxt   = bit_r;
        res_nxt   = res_r;
        tad_nxt   = tad_r;
        done_nxt  = 1'b0;
        unique case (state_r)
            IDLE: begin
                if (start) begin
                    state_nxt = CONV;
                    bit_nxt   = {1'b1, {(WIDTH-1){1'b0}}};
                    code_nxt  = {1'b1, {(WIDTH-1){1'b0}}};
                    tad_nxt   = tad_len - 8'h01;
                end
            end
            CONV: begin
                if (tad_r != 8'h00) begin
                    tad_nxt = tad_r - 8'h01;
                end else begin
                    tad_nxt = tad_len - 8'h01;
                    if (!comp_in) begin
                        code_nxt = code_r & ~bit_r;
                    end
                    if (bit_r[0]) begin
                        state_nxt = IDLE;
                        res_nxt   = comp_in ? code_r : (code_r & ~bit_r);
                        done_nxt  = 1'b1;
                    end else begin
                        bit_nxt  = bit_r >> 1;
                        code_nxt = (comp_in ? code_r : (code_r & ~bit_r))
                                 | (bit_r >> 1);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= IDLE;
            code_r  <= '0;
            bit_r   <= '0;
            res_r   <= '0;
            tad_r   <= 8'h00;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            code_r  <= code_nxt;
            bit_r   <= bit_nxt;
            res_r   <= res_nxt;
            tad_r   <= tad_nxt;
            done_r  <= done_nxt;
        end
    end

    assign sample_open = (state_r == CONV); // [R7]
    assign dac_code    = code_r;
    assign done        = done_r;
    assign result      = res_r;
endmodule : sar_engine

/* adc_conversion_trigger_control.sv */
// Converter control: registers, trigger acceptance, timer one clearing
`timescale 1ns/100ps
module adc_conversion_trigger_control #(
    parameter int WIDTH = adc_trig_pkg::CONV_BITS
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [7:0]            reg_rdata,
    input  wire logic             special_event,
    input  wire logic             comp_in,
    output logic [WIDTH-1:0]      dac_code,
    output logic [2:0]            channel_select,
    output logic                  converter_power_on,
    output logic                  sample_open,
    output logic [15:0]           timer_one
);
    // ********************
    // Register state
    // ********************
    logic [7:0]  ctrl_r, ctrl_nxt;
    logic [7:0]  pincfg_r, pincfg_nxt;
    logic [7:0]  cmp_r, cmp_nxt;
    logic [7:0]  flags_r, flags_nxt;
    logic [7:0]  en_r, en_nxt;
    logic [7:0]  intc_r, intc_nxt;
    logic [7:0]  pa_r, pa_nxt;
    logic [7:0]  dir_r, dir_nxt;
    logic [15:0] tmr_r, tmr_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        trig_ok;
    logic        start_conv;
    logic        eng_done;
    logic [WIDTH-1:0] eng_result;
    logic        go_wr_set;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // ********************
    // Trigger acceptance
    // ********************
    assign trig_ok = special_event
                   && (cmp_r[3:0] == adc_trig_pkg::SPECIAL_EVENT_MODE)
                   && ctrl_r[adc_trig_pkg::POWER_ON_BIT]; // [R1] [R4]
    // Software start only when converter already powered
    assign go_wr_set = reg_wr
                     && hit(reg_addr, adc_trig_pkg::CONV_CTRL_MAIN_OFS)
                     && reg_wdata[adc_trig_pkg::GO_BIT]
                     && ctrl_r[adc_trig_pkg::POWER_ON_BIT]
                     && !ctrl_r[adc_trig_pkg::GO_BIT]; // [R6]
    assign start_conv = go_wr_set
                      || (trig_ok && !ctrl_r[adc_trig_pkg::GO_BIT]); // [R2]

    // ********************
    // Control and flag registers
    // ********************
    always_comb begin
        ctrl_nxt  = ctrl_r;
        flags_nxt = flags_r;
        if (reg_wr && hit(reg_addr, adc_trig_pkg::CONV_CTRL_MAIN_OFS)) begin
            ctrl_nxt = reg_wdata & adc_trig_pkg::CTRL_MAIN_MASK;
            // Go bit is only set through a valid start
            ctrl_nxt[adc_trig_pkg::GO_BIT] =
                ctrl_r[adc_trig_pkg::GO_BIT]
                & reg_wdata[adc_trig_pkg::GO_BIT];
        end
        if (reg_wr && hit(reg_addr, adc_trig_pkg::PERIPH_FLAGS_OFS)) begin
            flags_nxt = reg_wdata & adc_trig_pkg::FLAGS_MASK;
        end
        if (start_conv) begin
            ctrl_nxt[adc_trig_pkg::GO_BIT] = 1'b1; // [R2]
        end
        if (eng_done) begin
            ctrl_nxt[adc_trig_pkg::GO_BIT] = 1'b0; // [R8]
            // Completion wins over a same-cycle software clear
            flags_nxt[adc_trig_pkg::DONE_FLAG_BIT] = 1'b1; // [R8]
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r  <= adc_trig_pkg::CTRL_MAIN_RST;
            flags_r <= 8'h00;
        end else begin
            ctrl_r  <= ctrl_nxt;
            flags_r <= flags_nxt;
        end
    end

    // ********************
    // Configuration registers
    // ********************
    // Plain storage, except compare control, whose mode bits gate trigger acceptance
    always_comb begin
        pincfg_nxt = pincfg_r;
        cmp_nxt    = cmp_r;
        en_nxt     = en_r;
        intc_nxt   = intc_r;
        pa_nxt     = pa_r;
        dir_nxt    = dir_r;
        if (reg_wr) begin
            unique case (reg_addr)
                adc_trig_pkg::CONV_PIN_CFG_OFS:
                    pincfg_nxt = reg_wdata & adc_trig_pkg::PIN_CFG_MASK;
                adc_trig_pkg::COMPARE_CTRL_OFS:
                    cmp_nxt = reg_wdata & adc_trig_pkg::COMPARE_MASK;
                adc_trig_pkg::PERIPH_ENABLES_OFS:
                    en_nxt = reg_wdata & adc_trig_pkg::FLAGS_MASK;
                adc_trig_pkg::CORE_INT_CTRL_OFS:
                    intc_nxt = reg_wdata;
                adc_trig_pkg::PORT_A_PINS_OFS:
                    pa_nxt = reg_wdata & adc_trig_pkg::PORT_A_MASK;
                adc_trig_pkg::PORT_A_DIR_OFS:
                    dir_nxt = reg_wdata & adc_trig_pkg::PORT_A_MASK;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pincfg_r <= 8'h00;
            cmp_r    <= 8'h00;
            en_r     <= 8'h00;
            intc_r   <= 8'h00;
            pa_r     <= 8'h00;
            dir_r    <= adc_trig_pkg::PORT_A_DIR_RST;
        end else begin
            pincfg_r <= pincfg_nxt;
            cmp_r    <= cmp_nxt;
            en_r     <= en_nxt;
            intc_r   <= intc_nxt;
            pa_r     <= pa_nxt;
            dir_r    <= dir_nxt;
        end
    end

    // ********************
    // Timer one
    // ********************
    always_comb begin
        tmr_nxt = tmr_r + 16'h0001;
        if (reg_wr && hit(reg_addr, adc_trig_pkg::TIMER_ONE_LO_OFS)) begin
            tmr_nxt = {tmr_r[15:8], reg_wdata};
        end
        if (reg_wr && hit(reg_addr, adc_trig_pkg::TIMER_ONE_HI_OFS)) begin
            tmr_nxt = {reg_wdata, tmr_r[7:0]};
        end
        // Trigger clear beats a same-cycle timer write
        if (special_event) begin
            tmr_nxt = 16'h0000; // [R3] [R4]
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tmr_r <= 16'h0000;
        end else begin
            tmr_r <= tmr_nxt;
        end
    end

    // ********************
    // Read path
    // ********************
    // Registered so that data stands exactly one cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                adc_trig_pkg::CONV_CTRL_MAIN_OFS: rdata_nxt = ctrl_r;
                adc_trig_pkg::CONV_PIN_CFG_OFS:   rdata_nxt = pincfg_r;
                adc_trig_pkg::COMPARE_CTRL_OFS:   rdata_nxt = cmp_r;
                adc_trig_pkg::PERIPH_FLAGS_OFS:   rdata_nxt = flags_r;
                adc_trig_pkg::PERIPH_ENABLES_OFS: rdata_nxt = en_r;
                adc_trig_pkg::CORE_INT_CTRL_OFS:  rdata_nxt = intc_r;
                adc_trig_pkg::PORT_A_PINS_OFS:    rdata_nxt = pa_r;
                adc_trig_pkg::PORT_A_DIR_OFS:     rdata_nxt = dir_r;
                adc_trig_pkg::CONV_RESULT_OFS:    rdata_nxt = 8'(eng_result);
                adc_trig_pkg::TIMER_ONE_LO_OFS:   rdata_nxt = tmr_r[7:0];
                adc_trig_pkg::TIMER_ONE_HI_OFS:   rdata_nxt = tmr_r[15:8];
                default:                          rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ********************
    // Conversion engine
    // ********************
    sar_engine #(
        .WIDTH       (WIDTH)
    ) u_sar (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .start       (start_conv),
        .clk_sel     (ctrl_r[adc_trig_pkg::CLKSEL_LSB +: 2]),
        .comp_in     (comp_in),
        .sample_open (sample_open),
        .dac_code    (dac_code),
        .done        (eng_done),
        .result      (eng_result)
    );

    // ********************
    // Outputs
    // ********************
    assign reg_rdata          = rdata_r;
    assign channel_select     = ctrl_r[adc_trig_pkg::CHAN_LSB +: 3];
    assign converter_power_on = ctrl_r[adc_trig_pkg::POWER_ON_BIT];
    assign timer_one          = tmr_r;
endmodule : adc_conversion_trigger_control

/* adc_trig_checker.sv */
// Checker: port-level properties of the converter control block
`timescale 1ns/100ps
module adc_trig_checker #(
    parameter int WIDTH = adc_trig_pkg::CONV_BITS
) (
    input wire logic             core_clk,
    input wire logic             rstn,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    input wire logic             special_event,
    input wire logic             comp_in,
    input wire logic [WIDTH-1:0] dac_code,
    input wire logic [2:0]       channel_select,
    input wire logic             converter_power_on,
    input wire logic             sample_open,
    input wire logic [15:0]      timer_one
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ********************
    // Sequences
    // ********************
    sequence conv_start;
        $rose(sample_open);
    endsequence
    sequence ctrl_write;
        reg_wr && reg_addr == adc_trig_pkg::CONV_CTRL_MAIN_OFS;
    endsequence
    // ********************
    // Properties
    // ********************
    timer_clear_a: assert property (special_event
        |=> timer_one == 16'h0000)
        else $error("timer not cleared by trigger");
    timer_count_a: assert property (!special_event && !reg_wr
        |=> timer_one == $past(timer_one) + 16'h0001)
        else $error("timer did not count");
    trig_off_a: assert property (special_event && !converter_power_on
        && !sample_open |=> !sample_open)
        else $error("trigger started an unpowered converter");
    hold_open_a: assert property (conv_start |-> sample_open[*8])
        else $error("sampling switch closed early");
    conv_end_a: assert property (conv_start |-> ##[1:140] !sample_open)
        else $error("conversion never completed");
    power_bit_a: assert property (ctrl_write
        |=> converter_power_on == $past(reg_wdata[0]))
        else $error("power bit not taken from write");
    chan_sel_a: assert property (ctrl_write
        |=> channel_select == $past(reg_wdata[5:3]))
        else $error("channel not taken from write");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule : adc_trig_checker
bind adc_conversion_trigger_control adc_trig_checker #(.WIDTH(WIDTH)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .special_event(special_event),
    .comp_in(comp_in), .dac_code(dac_code),
    .channel_select(channel_select),
    .converter_power_on(converter_power_on),
    .sample_open(sample_open), .timer_one(timer_one)
);

/* tb_top.sv */
// Testbench: register, software start and trigger scenarios
`timescale 1ns/100ps
module tb_top;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        reg_wr, reg_rd, special_event, comp_in;
    logic        converter_power_on, sample_open;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, dac_code, level;
    logic [2:0]  channel_select;
    logic [15:0] timer_one;
    int          err_total = 0;
    int          total_checks = 0;
    always #2.5 core_clk = ~core_clk;
    // Ideal comparator; a registered one would skew each trial
    assign comp_in = (level >= dac_code);
    adc_conversion_trigger_control u_dut (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .special_event(special_event),
        .comp_in(comp_in), .dac_code(dac_code),
        .channel_select(channel_select),
        .converter_power_on(converter_power_on),
        .sample_open(sample_open), .timer_one(timer_one));
    // ********************
    // Helpers
    // ********************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, e});
    endtask : rdc
    task automatic fire(input logic conv);
        @(posedge core_clk);
        special_event <= 1'b1;
        @(posedge core_clk);
        special_event <= 1'b0;
        #1 chk(timer_one, 16'h0000);
        repeat (2) @(posedge core_clk);
        #1 chk({15'h0000, sample_open}, {15'h0000, conv});
    endtask : fire
    task automatic finish_conv(input logic [7:0] exp);
        int n;
        n = 0;
        while (sample_open === 1'b1 && n < 300) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk({15'h0000, sample_open}, 16'h0000);
        chk({8'h00, dac_code}, {8'h00, exp});
        rdc(8'h1E, exp);
        rdc(8'h0C, 8'h40);
        wr(8'h0C, 8'h00);
        rdc(8'h0C, 8'h00);
    endtask : finish_conv
    // ********************
    // Scenarios
    // ********************
    task automatic t_regs();
        rdc(8'h1F, 8'h00);
        rdc(8'h85, 8'h3F);
        rdc(8'h0C, 8'h00);
        rdc(8'h50, 8'h00);
        wr(8'h9F, 8'hFF);
        rdc(8'h9F, 8'h07);
    endtask : t_regs
    task automatic t_soft();
        level <= 8'h5A;
        wr(8'h1F, 8'h04);
        repeat (2) @(posedge core_clk);
        #1 chk({15'h0000, sample_open}, 16'h0000);
        wr(8'h1F, 8'h01);
        wr(8'h1F, 8'h05);
        repeat (2) @(posedge core_clk);
        #1 chk({15'h0000, sample_open}, 16'h0001);
        rdc(8'h1F, 8'h05);
        finish_conv(8'h5A);
        rdc(8'h1F, 8'h01);
    endtask : t_soft
    task automatic t_trig();
        level <= 8'hC3;
        wr(8'h17, 8'h0B);
        wr(8'h1F, 8'h61);
        #1 chk({13'h0000, channel_select}, 16'h0004);
        chk({15'h0000, converter_power_on}, 16'h0001);
        repeat (20) @(posedge core_clk);
        fire(1'b1);
        finish_conv(8'hC3);
    endtask : t_trig
    task automatic t_mode();
        logic [7:0] modes [3] = '{8'h0A, 8'h03, 8'h08};
        foreach (modes[i]) begin
            wr(8'h17, modes[i]);
            fire(1'b0);
        end
    endtask : t_mode
    task automatic t_off();
        wr(8'h17, 8'h0B);
        wr(8'h1F, 8'h00);
        #1 chk({15'h0000, converter_power_on}, 16'h0000);
        fire(1'b0);
        rdc(8'h1F, 8'h00);
    endtask : t_off
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // Run takes about 150 cycles; over a hundred times that means a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        final_report();
    end
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        special_event = 1'b0;
        level = 8'h00;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        t_regs();
        t_soft();
        t_trig();
        t_mode();
        t_off();
        final_report();
    end
endmodule : tb_top
